// [bus_match_pkg.sv]
// Shared widths, geometry and size modes of the bus-matching queues.
package bus_match_pkg;

  // ==========================================================================
  // Widths and geometry
  // ==========================================================================
  localparam int DATA_W      = 36;  // Long word on both ports.
  localparam int HALF_W      = 18;  // Word lane on port B.
  localparam int BYTE_W      = 9;   // Byte lane on port B.
  localparam int QUEUE_DEPTH = 16;  // Long words held per direction.
  localparam int SYNC_STAGES = 2;   // Flops in each flag synchroniser.

  // Index of the final narrow transfer of one long word, per size mode.
  localparam logic [1:0] LAST_LONG = 2'h0;
  localparam logic [1:0] LAST_WORD = 2'h1;
  localparam logic [1:0] LAST_BYTE = 2'h3;
  localparam logic [1:0] FIRST_IDX = 2'h0;
  localparam logic [1:0] NEXT_IDX  = 2'h1;

  // ==========================================================================
  // Size modes
  // ==========================================================================
  typedef enum logic [2:0] {
    SIZE_LONG = 3'h1,
    SIZE_WORD = 3'h2,
    SIZE_BYTE = 3'h4
  } sizeMode_t;

  // ==========================================================================
  // Lane helpers
  // ==========================================================================
  // Slot of transfer number idx inside the long word: halves 1/0, bytes 3..0.
  function automatic logic [1:0] laneSlot(input logic [1:0] idx, input sizeMode_t mode, input logic big);
    logic [1:0] slot;
    slot = FIRST_IDX;
    if (mode == SIZE_WORD) begin
      slot = {1'b0, big ^ idx[0]};
    end else if (mode == SIZE_BYTE) begin
      slot = big ? (LAST_BYTE - idx) : idx;
    end
    return slot;
  endfunction

  // Narrow lane taken from a long word; unused upper lanes are driven zero.
  function automatic logic [DATA_W-1:0] extractLane(input logic [DATA_W-1:0] word, input logic [1:0] slot,
                                                    input sizeMode_t mode);
    logic [DATA_W-1:0] lane;
    lane = word;
    if (mode == SIZE_WORD) begin
      lane = {{(DATA_W-HALF_W){1'b0}}, word[slot[0]*HALF_W +: HALF_W]};
    end else if (mode == SIZE_BYTE) begin
      lane = {{(DATA_W-BYTE_W){1'b0}}, word[slot*BYTE_W +: BYTE_W]};
    end
    return lane;
  endfunction

  // Long word with one narrow lane from the low bits of bus replaced.
  function automatic logic [DATA_W-1:0] insertLane(input logic [DATA_W-1:0] word, input logic [DATA_W-1:0] bus,
                                                   input logic [1:0] slot, input sizeMode_t mode);
    logic [DATA_W-1:0] res;
    res = bus;
    if (mode == SIZE_WORD) begin
      res = word;
      res[slot[0]*HALF_W +: HALF_W] = bus[HALF_W-1:0];
    end else if (mode == SIZE_BYTE) begin
      res = word;
      res[slot*BYTE_W +: BYTE_W] = bus[BYTE_W-1:0];
    end
    return res;
  endfunction

endpackage

// [queue_stream_if.sv]
// Valid/ready stream between port logic and a queue.
`timescale 1ns/100ps
interface queue_stream_if #(parameter int WIDTH = 36);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [queue_mem.sv]
// Simple dual-port storage with a registered read port.
`timescale 1ns/100ps
module queue_mem #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input  wire logic                     mclk,
  input  wire logic                     wrEn,
  input  wire logic [$clog2(DEPTH)-1:0] wrAddr,
  input  wire logic [WIDTH-1:0]         wrData,
  input  wire logic [$clog2(DEPTH)-1:0] rdAddr,
  output logic      [WIDTH-1:0]         rdData
);

  logic [WIDTH-1:0] store [DEPTH];

  // The read is old-data on a same-address write; the queue hides that case.
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      store[wrAddr] <= wrData;
    end
    rdData <= store[rdAddr];
  end

endmodule

// [queue_fifo.sv]
// Show-ahead queue of long words with valid/ready on both sides.
`timescale 1ns/100ps
module queue_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 16
) (
  input wire logic    mclk,
  input wire logic    rst,
  queue_stream_if.snk inSide,
  queue_stream_if.src outSide
);

  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_COUNT = (PW+1)'(DEPTH);

  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0]   count;
  logic [PW:0]   next_count;
  logic          headFresh;
  wire           push;
  wire           pop;
  wire  [PW-1:0] rdAddr;

  // ==========================================================================
  // Handshake decode
  // ==========================================================================
  // A word just written into the head slot needs one more registered read,
  // so the head is held invalid for that cycle.
  assign push          = inSide.valid & inSide.ready;
  assign pop           = outSide.valid & outSide.ready;
  assign inSide.ready  = (count != FULL_COUNT);
  assign outSide.valid = (count != '0) & ~headFresh;
  assign rdAddr        = pop ? rdPtr + 1'b1 : rdPtr;

  // Occupancy after this edge.
  always_comb begin
    next_count = count;
    if (push & ~pop) begin
      next_count = count + 1'b1;
    end else if (pop & ~push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge mclk) begin
    if (rst) begin
      wrPtr     <= '0;
      rdPtr     <= '0;
      count     <= '0;
      headFresh <= 1'b0;
    end else begin
      if (push) begin
        wrPtr <= wrPtr + 1'b1;
      end
      rdPtr     <= rdAddr;
      count     <= next_count;
      headFresh <= push & (wrPtr == rdAddr);
    end
  end

  queue_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH)) mem (
    .mclk   (mclk),
    .wrEn   (push),
    .wrAddr (wrPtr),
    .wrData (inSide.data),
    .rdAddr (rdAddr),
    .rdData (outSide.data)
  );

endmodule

// [port_b_bus_matching_flags.sv]
// Two-direction queue pair with port B bus matching and empty/output-ready flags.
`timescale 1ns/100ps

// Contract
// RQ1: Size selects static; endian taken at reset.
// RQ2: Long-word mode passes all four lanes straight.
// RQ3: Two word writes pack one long word.
// RQ4: Four byte writes pack one long word.
// RQ5: Long word read out as two words.
// RQ6: Long word read out as four bytes.
// RQ7: Upper lanes undefined on word reads.
// RQ8: Upper lanes undefined on byte reads.
// RQ9: Port B output ready within three cycles.
// RQ10: Late crossing may add one port B cycle.
// RQ11: Output ready drops on last narrow read.
// RQ12: Port B empty flag rises next cycles.
// RQ13: Empty flag falls on last narrow read.
// RQ14: Port A output ready within three cycles.
// RQ15: Port A empty flag rises next cycles.
// RQ16: Only a complete long word reaches A.
// RQ17: Port B read needs select pattern, enable.
// RQ18: Port B write needs select pattern, enable.
// RQ19: Flags pass a two-flop synchroniser first.
// RQ20: Reads ignored while the flag is low.
module port_b_bus_matching_flags
  import bus_match_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              busMatchSelect,
  input  wire logic              sizeSelect,
  input  wire logic              endianSelect,
  input  wire logic              fallThroughMode,
  input  wire logic              chipSelectPortA_n,
  input  wire logic              writeReadSelectPortA,
  input  wire logic              mailboxSelectPortA,
  input  wire logic              portAEnable,
  input  wire logic [DATA_W-1:0] portADataIn,
  output logic      [DATA_W-1:0] portADataOut,
  output logic                   portADataOe,
  output logic                   emptyFlagPortA,
  output logic                   outputReadyPortA,
  output logic                   inputReadyPortA,
  input  wire logic              chipSelectPortB_n,
  input  wire logic              writeReadSelectPortB,
  input  wire logic              mailboxSelectPortB,
  input  wire logic              portBEnable,
  input  wire logic [DATA_W-1:0] portBDataIn,
  output logic      [DATA_W-1:0] portBDataOut,
  output logic                   portBDataOe,
  output logic                   emptyFlagPortB,
  output logic                   outputReadyPortB,
  output logic                   inputReadyPortB
);

  // ==========================================================================
  // Captured configuration
  // ==========================================================================
  logic      endianBig;
  logic      fallThrough;
  sizeMode_t sizeMode;
  wire [1:0] lastIdx;

  // RQ1 endian at reset.
  // Endian and flag mode are caught only while reset is held, so a later
  // wiggle on those pins cannot reorder a half-packed long word.
  always_ff @(posedge mclk) begin
    if (rst) begin
      endianBig   <= endianSelect;
      fallThrough <= fallThroughMode;
    end
  end

  // RQ1 static size selects.
  // Bus-match and size are read live; changing them mid-stream corrupts the
  // lane counters, which is why the outside party must keep them still.
  assign sizeMode = !busMatchSelect ? SIZE_LONG : (sizeSelect ? SIZE_BYTE : SIZE_WORD);
  assign lastIdx  = (sizeMode == SIZE_BYTE) ? LAST_BYTE :
                    (sizeMode == SIZE_WORD) ? LAST_WORD : LAST_LONG;

  // ==========================================================================
  // Port request decode
  // ==========================================================================
  wire aSel;
  wire bSel;
  wire aWriteReq;
  wire aReadReq;
  wire bWriteReq;
  wire bReadReq;

  // Queue access needs chip select low, mailbox select low and the enable;
  // mailbox accesses fall through to nothing here.
  assign aSel      = ~chipSelectPortA_n & ~mailboxSelectPortA & portAEnable;
  assign bSel      = ~chipSelectPortB_n & ~mailboxSelectPortB & portBEnable;
  assign aWriteReq = aSel & writeReadSelectPortA;
  assign aReadReq  = aSel & ~writeReadSelectPortA;
  // RQ18 port B write pattern.
  assign bWriteReq = bSel & ~writeReadSelectPortB;
  // RQ17 port B read pattern.
  assign bReadReq  = bSel & writeReadSelectPortB;

  // Data pins are driven whenever the port is selected for reading.
  assign portADataOe = ~chipSelectPortA_n & ~writeReadSelectPortA;
  assign portBDataOe = ~chipSelectPortB_n & writeReadSelectPortB;

  // ==========================================================================
  // Queues
  // ==========================================================================
  queue_stream_if #(.WIDTH(DATA_W)) abIn ();
  queue_stream_if #(.WIDTH(DATA_W)) abOut ();
  queue_stream_if #(.WIDTH(DATA_W)) baIn ();
  queue_stream_if #(.WIDTH(DATA_W)) baOut ();

  queue_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) queueAToB (
    .mclk    (mclk),
    .rst     (rst),
    .inSide  (abIn),
    .outSide (abOut)
  );

  queue_fifo #(.WIDTH(DATA_W), .DEPTH(QUEUE_DEPTH)) queueBToA (
    .mclk    (mclk),
    .rst     (rst),
    .inSide  (baIn),
    .outSide (baOut)
  );

  // Port A writes go straight in as long words; a full queue refuses them.
  assign abIn.valid      = aWriteReq;
  assign abIn.data       = portADataIn;
  assign inputReadyPortA = abIn.ready;

  // ==========================================================================
  // Port B write packing
  // ==========================================================================
  logic [1:0]        packIdx;
  logic [DATA_W-1:0] packWord;
  wire  [1:0]        packSlot;
  wire  [DATA_W-1:0] packNext;
  wire               bWriteAcc;
  wire               packLast;

  // RQ3 word packing order.
  // RQ4 byte packing order.
  // RQ2 long-word pass-through.
  // The slot of each narrow write follows the endian; long-word mode has a
  // single transfer that replaces the whole word.
  assign packSlot  = laneSlot(packIdx, sizeMode, endianBig);
  assign packNext  = insertLane(packWord, portBDataIn, packSlot, sizeMode);
  assign packLast  = (packIdx == lastIdx);
  assign bWriteAcc = bWriteReq & baIn.ready;

  // RQ16 push only completed words.
  // Port A sees nothing until the final narrow write lands, so its flag
  // timing starts from that port B edge.
  assign baIn.valid      = bWriteReq & packLast;
  assign baIn.data       = packNext;
  // Narrow writes are also held off while full; simpler than letting them
  // pile up into a word that could not be pushed.
  assign inputReadyPortB = baIn.ready;

  // Packing counter and partial word.
  always_ff @(posedge mclk) begin
    if (rst) begin
      packIdx  <= FIRST_IDX;
      packWord <= '0;
    end else if (bWriteAcc) begin
      packIdx  <= packLast ? FIRST_IDX : packIdx + 1'b1;
      packWord <= packNext;
    end
  end

  // ==========================================================================
  // Flag synchronisers
  // ==========================================================================
  logic [SYNC_STAGES-1:0] abSync;
  logic [SYNC_STAGES-1:0] baSync;
  wire                    availB;
  wire                    availA;

  // RQ19 two-flop flag crossing.
  // Only the rise of queue occupancy goes through the flops; the fall is seen
  // at once so a reader can never pop an empty queue.
  always_ff @(posedge mclk) begin
    if (rst) begin
      abSync <= '0;
      baSync <= '0;
    end else begin
      abSync <= {abSync[SYNC_STAGES-2:0], abOut.valid};
      baSync <= {baSync[SYNC_STAGES-2:0], baOut.valid};
    end
  end

  // RQ10 late crossing slack.
  // A word arriving just before an edge shows one cycle later than one that
  // arrived earlier; both stay inside the allowance.
  assign availB = abOut.valid & abSync[SYNC_STAGES-1];
  assign availA = baOut.valid & baSync[SYNC_STAGES-1];

  // ==========================================================================
  // Port B read unpacking and flags
  // ==========================================================================
  logic [1:0]        laneIdxB;
  logic [DATA_W-1:0] heldB;
  logic              outValidB;
  wire               haveLanesB;
  wire               srcAvailB;
  wire               flagB;
  wire               bReadAcc;
  wire               advB;
  wire               popB;
  wire  [1:0]        readIdxB;
  wire  [1:0]        readSlotB;
  wire  [DATA_W-1:0] readWordB;

  // Lanes left in the held word count as stored data for the flags.
  assign haveLanesB = (laneIdxB != FIRST_IDX);
  assign srcAvailB  = haveLanesB | availB;

  // RQ13 empty falls on last lane.
  // RQ11 output ready falls on last lane.
  assign flagB            = fallThrough ? outValidB : srcAvailB;
  assign emptyFlagPortB   = ~fallThrough & srcAvailB;
  assign outputReadyPortB = fallThrough & outValidB;

  // RQ20 reads gated by flag.
  assign bReadAcc = bReadReq & flagB;

  // RQ9 fall-through preload.
  // RQ12 standard read on demand.
  // In fall-through the output register refills itself whenever it is empty
  // or being read; in standard mode it loads only on an accepted read.
  assign advB = fallThrough ? ((~outValidB | bReadAcc) & srcAvailB) : bReadAcc;
  assign popB = advB & ~haveLanesB;
  assign abOut.ready = popB;

  // RQ5 word read order.
  // RQ6 byte read order.
  assign readIdxB  = haveLanesB ? laneIdxB : FIRST_IDX;
  assign readWordB = haveLanesB ? heldB : abOut.data;
  assign readSlotB = laneSlot(readIdxB, sizeMode, endianBig);

  // RQ7 word upper lanes zero.
  // RQ8 byte upper lanes zero.
  // Undefined lanes are driven zero rather than left floating on the bus.
  always_ff @(posedge mclk) begin
    if (rst) begin
      portBDataOut <= '0;
    end else if (advB) begin
      portBDataOut <= extractLane(readWordB, readSlotB, sizeMode);
    end
  end

  // Lane counter, held long word and output-valid state.
  always_ff @(posedge mclk) begin
    if (rst) begin
      laneIdxB  <= FIRST_IDX;
      heldB     <= '0;
      outValidB <= 1'b0;
    end else begin
      if (advB) begin
        if (haveLanesB) begin
          laneIdxB <= (laneIdxB == lastIdx) ? FIRST_IDX : laneIdxB + 1'b1;
        end else begin
          laneIdxB <= (lastIdx == LAST_LONG) ? FIRST_IDX : NEXT_IDX;
        end
      end
      if (popB) begin
        heldB <= abOut.data;
      end
      if (advB) begin
        outValidB <= 1'b1;
      end else if (bReadAcc) begin
        outValidB <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Port A read and flags
  // ==========================================================================
  logic outValidA;
  wire  flagA;
  wire  aReadAcc;
  wire  advA;

  // RQ15 standard empty flag.
  // RQ14 fall-through output ready.
  assign flagA            = fallThrough ? outValidA : availA;
  assign emptyFlagPortA   = ~fallThrough & availA;
  assign outputReadyPortA = fallThrough & outValidA;

  // RQ20 reads gated by flag.
  assign aReadAcc    = aReadReq & flagA;
  assign advA        = fallThrough ? ((~outValidA | aReadAcc) & availA) : aReadAcc;
  assign baOut.ready = advA;

  // Port A output register and fall-through state.
  always_ff @(posedge mclk) begin
    if (rst) begin
      portADataOut <= '0;
      outValidA    <= 1'b0;
    end else begin
      if (advA) begin
        portADataOut <= baOut.data;
      end
      if (advA) begin
        outValidA <= 1'b1;
      end else if (aReadAcc) begin
        outValidA <= 1'b0;
      end
    end
  end

endmodule

// [port_b_bus_matching_flags_chk.sv]
// Port-level checks on the queue pair's flags and reads.
`timescale 1ns/100ps
module port_b_bus_matching_flags_chk
  import bus_match_pkg::*;
(
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              chipSelectPortA_n,
  input wire logic              writeReadSelectPortA,
  input wire logic              mailboxSelectPortA,
  input wire logic              portAEnable,
  input wire logic [DATA_W-1:0] portADataOut,
  input wire logic              emptyFlagPortA,
  input wire logic              outputReadyPortA,
  input wire logic              chipSelectPortB_n,
  input wire logic              writeReadSelectPortB,
  input wire logic              mailboxSelectPortB,
  input wire logic              portBEnable,
  input wire logic [DATA_W-1:0] portBDataOut,
  input wire logic              emptyFlagPortB,
  input wire logic              outputReadyPortB
);
  // ====================
  // Request decode
  // ====================
  // Refused writes reset the age too; that only loosens the bound.
  wire aWrite = ~chipSelectPortA_n & writeReadSelectPortA & ~mailboxSelectPortA & portAEnable;
  wire aRead  = ~chipSelectPortA_n & ~writeReadSelectPortA & ~mailboxSelectPortA & portAEnable;
  wire bWrite = ~chipSelectPortB_n & ~writeReadSelectPortB & ~mailboxSelectPortB & portBEnable;
  wire bRead  = ~chipSelectPortB_n & writeReadSelectPortB & ~mailboxSelectPortB & portBEnable;
  logic [2:0] ageA;
  logic [2:0] ageB;

  // Edges since the last write per port, saturating.
  always_ff @(posedge mclk) begin
    ageA <= rst ? 3'h7 : aWrite ? 3'h0 : ageA + {2'h0, ageA != 3'h7};
    ageB <= rst ? 3'h7 : bWrite ? 3'h0 : ageB + {2'h0, ageB != 3'h7};
  end

  // ====================
  // Properties
  // ====================
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_reset_clear: assert property (disable iff (1'b0) rst |=> !emptyFlagPortB && !outputReadyPortB
    && !emptyFlagPortA && !outputReadyPortA && portBDataOut == '0 && portADataOut == '0)
    else $error("Reset left flags or data set.");
  a_b_empty_rise: assert property ($rose(emptyFlagPortB) |-> ageA <= 3'h4)
    else $error("B empty rose late.");
  a_b_ready_rise: assert property ($rose(outputReadyPortB) |-> ageA <= 3'h5)
    else $error("B ready rose late.");
  a_a_empty_rise: assert property ($rose(emptyFlagPortA) |-> ageB <= 3'h4)
    else $error("A empty rose late.");
  a_a_ready_rise: assert property ($rose(outputReadyPortA) |-> ageB <= 3'h5)
    else $error("A ready rose late.");
  a_b_empty_fall: assert property ($fell(emptyFlagPortB) |-> $past(bRead) || $past(rst))
    else $error("B empty fell unread.");
  a_b_ready_fall: assert property ($fell(outputReadyPortB) |-> $past(bRead) || $past(rst))
    else $error("B ready fell unread.");
  a_a_flag_fall: assert property ($fell(emptyFlagPortA) || $fell(outputReadyPortA) |-> $past(aRead) || $past(rst))
    else $error("A flag fell unread.");
  a_b_read_ignored: assert property (bRead && !emptyFlagPortB && !outputReadyPortB
    |=> outputReadyPortB || $stable(portBDataOut)) else $error("B data moved unread.");
  a_a_read_ignored: assert property (aRead && !emptyFlagPortA && !outputReadyPortA
    |=> outputReadyPortA || $stable(portADataOut)) else $error("A data moved unread.");
  a_flag_modes_apart: assert property (!(emptyFlagPortB && outputReadyPortB) && !(emptyFlagPortA && outputReadyPortA))
    else $error("Both flag modes on.");

  c_b_drain: cover property ($fell(emptyFlagPortB));
  c_b_fall_through: cover property ($rose(outputReadyPortB));
  c_a_arrival: cover property ($rose(emptyFlagPortA));
  c_b_idle_read: cover property (bRead && !emptyFlagPortB && !outputReadyPortB);
endmodule

// [port_host.sv]
// Bus party model for one queue port.
`timescale 1ns/100ps
module port_host
  import bus_match_pkg::*;
#(
  parameter logic WR_LEVEL = 1'b1
) (
  input  wire logic              mclk,
  input  wire logic              inputReady,
  input  wire logic [DATA_W-1:0] dataIn,
  output logic                   chipSelect_n,
  output logic                   writeReadSelect,
  output logic                   mailboxSelect,
  output logic                   enable,
  output logic      [DATA_W-1:0] dataOut
);
  // ====================
  // Bus tasks
  // ====================
  logic [DATA_W-1:0] lastData = '0;

  // Released data shows the inverse of the last value, so stale captures fail.
  task automatic release_bus();
    chipSelect_n = 1'b1;
    enable = 1'b0;
    writeReadSelect = ~WR_LEVEL;
    mailboxSelect = 1'b0;
    dataOut = ~lastData;
  endtask

  initial release_bus();

  task automatic put(input logic [DATA_W-1:0] d, output bit ok);
    int k;
    chipSelect_n = 1'b0;
    writeReadSelect = WR_LEVEL;
    enable = 1'b1;
    dataOut = d;
    lastData = d;
    for (k = 0; k < 20 && !inputReady; k++) @(negedge mclk);
    ok = inputReady;
    @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic get(input logic showAhead, output logic [DATA_W-1:0] d);
    chipSelect_n = 1'b0;
    writeReadSelect = ~WR_LEVEL;
    enable = 1'b1;
    dataOut = ~lastData;
    d = dataIn;
    @(posedge mclk);
    @(negedge mclk);
    if (!showAhead) d = dataIn;
  endtask

  task automatic idle();
    release_bus();
    @(negedge mclk);
  endtask
endmodule

// [tb_top.sv]
// Self-checking bench for the queue pair.
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("BAD at %0t got %h expected %h", $time, got, exp); \
  end \
end
module tb_top
  import bus_match_pkg::*;
();
  // ====================
  // Design and port parties
  // ====================
  logic              mclk = 1'b0;
  logic              rst = 1'b1;
  logic              busMatchSelect = 1'b0;
  logic              sizeSelect = 1'b0;
  logic              endianSelect = 1'b0;
  logic              fallThroughMode = 1'b0;
  logic              chipSelectPortA_n, writeReadSelectPortA, mailboxSelectPortA, portAEnable;
  logic              chipSelectPortB_n, writeReadSelectPortB, mailboxSelectPortB, portBEnable;
  logic [DATA_W-1:0] portADataIn, portADataOut, portBDataIn, portBDataOut;
  logic              portADataOe, emptyFlagPortA, outputReadyPortA, inputReadyPortA;
  logic              portBDataOe, emptyFlagPortB, outputReadyPortB, inputReadyPortB;
  int                n_mismatch = 0;
  int                samples_checked = 0;
  int                seed = 32'hf432fcd3;

  always #5 mclk = ~mclk;

  port_b_bus_matching_flags uut (.*);
  port_host #(.WR_LEVEL(1'b1)) hostA (.mclk(mclk), .inputReady(inputReadyPortA), .dataIn(portADataOut),
    .chipSelect_n(chipSelectPortA_n), .writeReadSelect(writeReadSelectPortA),
    .mailboxSelect(mailboxSelectPortA), .enable(portAEnable), .dataOut(portADataIn));
  port_host #(.WR_LEVEL(1'b0)) hostB (.mclk(mclk), .inputReady(inputReadyPortB), .dataIn(portBDataOut),
    .chipSelect_n(chipSelectPortB_n), .writeReadSelect(writeReadSelectPortB),
    .mailboxSelect(mailboxSelectPortB), .enable(portBEnable), .dataOut(portBDataIn));

  // ====================
  // Helpers
  // ====================
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic bail(input bit ok);
    if (!ok) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  function automatic logic [DATA_W-1:0] rnd36();
    return {4'($random(seed)), 32'($random(seed))};
  endfunction

  // Mode m: 0 long, 1/2 word big/little, 3/4 byte big/little; lane in low bits.
  function automatic logic [DATA_W-1:0] lane(input logic [DATA_W-1:0] w, input int idx, input int m);
    int s;
    s = (m == 1) ? 1 - idx : (m == 3) ? 3 - idx : idx;
    if (m == 0) return w;
    if (m < 3) return {18'h0, w[s*18 +: 18]};
    return {27'h0, w[s*9 +: 9]};
  endfunction

  function automatic logic flag(input logic sideB, input logic ft);
    if (sideB) return ft ? outputReadyPortB : emptyFlagPortB;
    return ft ? outputReadyPortA : emptyFlagPortA;
  endfunction

  task automatic do_reset(input int m, input logic ft);
    rst = 1'b1;
    busMatchSelect = 1'(m != 0);
    sizeSelect = 1'(m > 2);
    endianSelect = 1'(m == 1 || m == 3);
    fallThroughMode = ft;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
  endtask

  // Bounded wait for data; the count is held to the mode's bound.
  task automatic wait_flag(input logic sideB, input logic ft, input int lim);
    int k;
    for (k = 0; k < 12 && flag(sideB, ft) !== 1'b1; k++) @(negedge mclk);
    bail(k < 12);
    `CHK(1'(k <= lim + ft), 1'b1)
  endtask

  // ====================
  // Scenarios
  // ====================
  // One mode: refused reads, two long words to B, one packed word to A.
  task automatic run_cfg(input int m, input logic ft);
    logic [DATA_W-1:0] w, w2, v, d;
    int n, i;
    bit ok;
    n = (m == 0) ? 1 : (m < 3) ? 2 : 4;
    do_reset(m, ft);
    hostA.get(ft, d);
    hostB.get(ft, d);
    hostA.idle();
    hostB.idle();
    `CHK(portADataOut, 36'h0)
    `CHK(portBDataOut, 36'h0)
    w = rnd36();
    w2 = rnd36();
    hostA.put(w, ok);
    bail(ok);
    hostA.put(w2, ok);
    bail(ok);
    hostA.idle();
    `CHK(flag(1'b1, ft), 1'b0)
    wait_flag(1'b1, ft, 2);
    for (i = 0; i < 2 * n; i++) begin
      hostB.get(ft, d);
      `CHK(d, lane(i < n ? w : w2, i % n, m))
      `CHK(flag(1'b1, ft), 1'(i < 2 * n - 1))
    end
    hostB.idle();
    v = rnd36();
    for (i = 0; i < n; i++) begin
      if (i == n - 1 && n > 1) begin
        hostB.idle();
        repeat (5) @(negedge mclk);
        `CHK(flag(1'b0, ft), 1'b0)
      end
      hostB.put(lane(v, i, m) | (rnd36() & (m == 0 ? 36'h0 : m < 3 ? 36'hffffc0000 : 36'hffffffe00)), ok);
      bail(ok);
    end
    hostB.idle();
    wait_flag(1'b0, ft, 3);
    hostA.get(ft, d);
    hostA.idle();
    `CHK(d, v)
    `CHK(flag(1'b0, ft), 1'b0)
  endtask

  // Fill A-to-B to its depth and check input ready is low, drain with random reader stalls.
  task automatic fill_drain();
    logic [DATA_W-1:0] q [QUEUE_DEPTH], d;
    int i;
    bit ok;
    do_reset(0, 1'b0);
    for (i = 0; i < QUEUE_DEPTH; i++) begin
      q[i] = rnd36();
      hostA.put(q[i], ok);
      bail(ok);
    end
    hostA.idle();
    `CHK(inputReadyPortA, 1'b0)
    for (i = 0; i < QUEUE_DEPTH; i++) begin
      if ($random(seed) & 1) hostB.idle();
      hostB.get(1'b0, d);
      `CHK(d, q[i])
    end
    hostB.idle();
    `CHK({portADataOe, portBDataOe}, 2'h0)
    `CHK(emptyFlagPortB, 1'b0)
    `CHK(inputReadyPortA, 1'b1)
  endtask

  // Every size and endian mode in both flag modes, then a full queue.
  initial begin
    for (int c = 0; c < 10; c++) run_cfg(c / 2, 1'(c % 2));
    fill_drain();
    stop_test();
  end

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    n_mismatch++;
    stop_test();
  end
endmodule

bind port_b_bus_matching_flags port_b_bus_matching_flags_chk chk (.*);
